// ==== hw/smfd_regs.svh ====
// reset values and fixed counts of the select-fault block
// assumes inclusion by bare name from the design files
`ifndef SMFD_REGS_SVH
`define SMFD_REGS_SVH

// reset values of the software-visible bits
`define SMFD_RST_PORT_ENABLE   1'b0
`define SMFD_RST_MASTER_SELECT 1'b0
`define SMFD_RST_TX_EMPTY      1'b1
`define SMFD_RST_FAULT_FLAG    1'b0

// data bits per transfer, counted from zero in the link domain
`define SMFD_LAST_BIT_IDX      3'h7
`define SMFD_BIT_CNT_W         3

// synchroniser width and cycles the link reset is honoured after release
`define SMFD_SYNC_BITS         4
`define SMFD_LINK_SETTLE       2'h3

`endif

// ==== hw/smfd_pkg.sv ====
// types shared by the select-fault block
// assumes the constants header is compiled alongside
package smfd_pkg;

   // slave transfer tracking, one-hot
   typedef enum logic [2:0] {
      XFER_IDLE   = 3'b001,
      XFER_ACTIVE = 3'b010,
      XFER_ENDING = 3'b100
   } smfd_xfer_t;

endpackage

// ==== hw/smfd_link_if.sv ====
// carrier between the bus-clock logic and the serial-clock counter
// assumes the counter sits on the serial clock pin domain
`timescale 1ns/1ps

interface smfd_link_if;
   logic link_rst_n;   // from bus domain, register output
   logic start_tgl;    // toggles on the first rising edge of each byte
   logic done_tgl;     // toggles on the eighth rising edge of each byte

   modport link (input link_rst_n, output start_tgl, output done_tgl);
   modport bus  (output link_rst_n, input start_tgl, input done_tgl);
endinterface

// ==== hw/smfd_sync.sv ====
// two-flop synchronisers for a group of levels
// assumes every input bit is a level that may change at any time
`timescale 1ns/1ps
`include "smfd_regs.svh"

module smfd_sync (
   input  wire logic                      i_clk,   // bus clock
   input  wire logic                      i_rst_n, // sync reset, active low
   input  wire logic [`SMFD_SYNC_BITS-1:0] i_async, // raw levels
   output logic      [`SMFD_SYNC_BITS-1:0] o_sync   // synchronised levels
);

   ////////////////////////////////////////////////////////////////////////
   // one chain per bit; the first flop feeds only the second
   genvar g;
   generate
      for (g = 0; g < `SMFD_SYNC_BITS; g = g + 1) begin : g_bit
         logic meta_ff;
         logic sync_ff;
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else begin
               meta_ff <= i_async[g];
               sync_ff <= meta_ff;
            end
         end
         assign o_sync[g] = sync_ff;
      end
   endgenerate

endmodule

// ==== hw/smfd_link_mon.sv ====
// bit counter clocked by the incoming serial clock
// assumes the bus side holds link_rst_n low while the port is deselected
`timescale 1ns/1ps

module smfd_link_mon (
   input  wire logic i_serial_clock_pin, // link clock from the far master
   smfd_link_if.link lnk                 // toggles to the bus domain
);
`include "smfd_regs.svh"

   logic [`SMFD_BIT_CNT_W-1:0] bit_cnt_ff;
   logic [`SMFD_BIT_CNT_W-1:0] nxt_bit_cnt;
   logic                       start_ff;
   logic                       nxt_start;
   logic                       done_ff;
   logic                       nxt_done;

   ////////////////////////////////////////////////////////////////////////
   // clock may stop between frames, so only edge events leave here
   always_comb begin
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      nxt_start   = start_ff ^ (bit_cnt_ff == 3'h0);
      nxt_done    = done_ff ^ (bit_cnt_ff == `SMFD_LAST_BIT_IDX);
   end

   // async reset only to constants; released by a bus-domain register
   always_ff @(posedge i_serial_clock_pin or negedge lnk.link_rst_n) begin
      if (!lnk.link_rst_n) begin
         bit_cnt_ff <= 3'h0;
         start_ff   <= 1'b0;
         done_ff    <= 1'b0;
      end else begin
         bit_cnt_ff <= nxt_bit_cnt;
         start_ff   <= nxt_start;
         done_ff    <= nxt_done;
      end
   end

   assign lnk.start_tgl = start_ff;
   assign lnk.done_tgl  = done_ff;

endmodule

// ==== hw/smfd_top.sv ====
// select-fault detection and recovery of a master/slave serial port
// assumes software strobes are one bus-clock pulses; pins are asynchronous
`timescale 1ns/1ps

module smfd_top (
   input  wire logic i_clk,                  // bus clock, 25 MHz
   input  wire logic i_rst_n,                // sync reset, active low
   input  wire logic i_serial_clock_pin,     // link clock pin
   input  wire logic i_slave_select_n,       // select pin, active low
   input  wire logic i_clock_polarity,       // idle level of serial clock
   input  wire logic i_clock_phase,          // 0: select starts transfer
   input  wire logic i_fault_detect_enable,  // enables fault detection
   input  wire logic i_error_irq_enable,     // enables error interrupt
   input  wire logic i_ctrl_wr,              // control register write
   input  wire logic i_ctrl_port_enable,     // written port enable
   input  wire logic i_ctrl_master_select,   // written master select
   input  wire logic i_stat_rd,              // status register read
   input  wire logic i_tx_load,              // data write, clears tx empty
   output logic      o_select_fault_flag,    // fault flag, register
   output logic      o_port_enable,          // port enable, register
   output logic      o_master_select,        // master select, register
   output logic      o_tx_empty_flag,        // tx empty, register
   output logic      o_err_irq,              // receiver/error request
   output logic      o_miso_oe,              // miso driver enable
   output logic      o_pins_to_port,         // pins under direction reg
   output logic      o_xfer_active           // slave transfer in progress
);
`include "smfd_regs.svh"

   smfd_link_if lnk ();

   logic [`SMFD_SYNC_BITS-1:0] sync_q;
   logic                       ss_n_s;
   logic                       sck_s;
   logic                       start_s;
   logic                       done_s;

   logic                       port_enable_ff;
   logic                       nxt_port_enable;
   logic                       master_select_ff;
   logic                       nxt_master_select;
   logic                       tx_empty_ff;
   logic                       nxt_tx_empty;
   logic                       fault_flag_ff;
   logic                       nxt_fault_flag;
   logic                       clr_armed_ff;
   logic                       nxt_clr_armed;
   smfd_pkg::smfd_xfer_t       xfer_ff;
   smfd_pkg::smfd_xfer_t       nxt_xfer;

   logic                       ss_n_d_ff;
   logic                       start_d_ff;
   logic                       done_d_ff;
   logic                       link_rst_n_ff;
   logic                       nxt_link_rst_n;
   logic [1:0]                 settle_ff;
   logic [1:0]                 nxt_settle;

   logic                       ss_fall;
   logic                       ss_rise;
   logic                       start_ev;
   logic                       done_ev;
   logic                       slave_on;
   logic                       master_fault;
   logic                       slave_fault;
   logic                       fault_now;

   ////////////////////////////////////////////////////////////////////////
   // pin and cross-domain inputs pass two flops first
   // select goes through inverted: a cleared chain then reads deselected,
   // so no false select edge follows reset
   smfd_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async ({lnk.done_tgl, lnk.start_tgl,
                 i_serial_clock_pin, ~i_slave_select_n}),
      .o_sync  (sync_q)
   );

   assign ss_n_s  = ~sync_q[0];
   assign sck_s   = sync_q[1];
   assign start_s = sync_q[2];
   assign done_s  = sync_q[3];

   // serial clock counter on its own domain
   smfd_link_mon u_link (
      .i_serial_clock_pin (i_serial_clock_pin),
      .lnk                (lnk.link)
   );

   ////////////////////////////////////////////////////////////////////////
   // event detection on synchronised levels
   assign ss_fall  = ss_n_d_ff & ~ss_n_s;
   assign ss_rise  = ~ss_n_d_ff & ss_n_s;
   // toggles are trusted only once the link reset has settled
   assign start_ev = (start_s != start_d_ff) & (settle_ff == 2'h0);
   assign done_ev  = (done_s != done_d_ff) & (settle_ff == 2'h0);
   assign slave_on = port_enable_ff & ~master_select_ff;

   assign master_fault = master_select_ff & i_fault_detect_enable &
                         ~ss_n_s;
   // phase 0 covered since selection alone enters the active state
   assign slave_fault  = ~master_select_ff & i_fault_detect_enable &
                         ss_rise & (xfer_ff != smfd_pkg::XFER_IDLE);
   assign fault_now    = master_fault | slave_fault;

   ////////////////////////////////////////////////////////////////////////
   // link reset: held while deselected, disabled or master
   always_comb begin
      nxt_link_rst_n = slave_on & ~ss_n_s;
      if (!link_rst_n_ff) begin
         nxt_settle = `SMFD_LINK_SETTLE;
      end else if (settle_ff != 2'h0) begin
         nxt_settle = settle_ff - 2'h1;
      end else begin
         nxt_settle = 2'h0;
      end
   end

   // delayed copies for edge and toggle detection
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         link_rst_n_ff <= 1'b0;
         settle_ff     <= `SMFD_LINK_SETTLE;
         ss_n_d_ff     <= 1'b1;
         start_d_ff    <= 1'b0;
         done_d_ff     <= 1'b0;
      end else begin
         link_rst_n_ff <= nxt_link_rst_n;
         settle_ff     <= nxt_settle;
         ss_n_d_ff     <= ss_n_s;
         start_d_ff    <= start_s;
         done_d_ff     <= done_s;
      end
   end

   assign lnk.link_rst_n = link_rst_n_ff;

   ////////////////////////////////////////////////////////////////////////
   // slave transfer tracking
   always_comb begin
      nxt_xfer = xfer_ff;
      unique case (xfer_ff)
         smfd_pkg::XFER_IDLE: begin
            if (slave_on & ~i_clock_phase & ss_fall) begin
               nxt_xfer = smfd_pkg::XFER_ACTIVE;
            end else if (slave_on & start_ev) begin
               nxt_xfer = smfd_pkg::XFER_ACTIVE;
            end
         end
         smfd_pkg::XFER_ACTIVE: begin
            if (done_ev) begin
               nxt_xfer = smfd_pkg::XFER_ENDING;
            end
         end
         smfd_pkg::XFER_ENDING: begin
            // ends once clock is back at idle
            if (start_ev) begin
               nxt_xfer = smfd_pkg::XFER_ACTIVE;
            end else if (sck_s == i_clock_polarity) begin
               nxt_xfer = smfd_pkg::XFER_IDLE;
            end
         end
         default: nxt_xfer = smfd_pkg::XFER_IDLE;
      endcase
      // abandon on disable; state cleared on master fault
      if (!port_enable_ff | master_select_ff | master_fault) begin
         nxt_xfer = smfd_pkg::XFER_IDLE;
      end else if (ss_n_s) begin
         // deselection always ends the transfer, faulted or not
         nxt_xfer = smfd_pkg::XFER_IDLE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         xfer_ff <= smfd_pkg::XFER_IDLE;
      end else begin
         xfer_ff <= nxt_xfer;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control bits, fault flag and clear sequence
   always_comb begin
      nxt_port_enable   = port_enable_ff;
      nxt_master_select = master_select_ff;
      nxt_tx_empty      = tx_empty_ff;
      nxt_fault_flag    = fault_flag_ff;
      nxt_clr_armed     = clr_armed_ff;
      if (i_ctrl_wr) begin
         nxt_port_enable   = i_ctrl_port_enable;
         nxt_master_select = i_ctrl_master_select;
      end
      if (i_tx_load) begin
         nxt_tx_empty = 1'b0;
      end
      // status read arms, control write clears
      // clear only with no fault during the sequence
      if (i_stat_rd & fault_flag_ff) begin
         nxt_clr_armed = 1'b1;
      end
      if (i_ctrl_wr & clr_armed_ff) begin
         nxt_fault_flag = 1'b0;
         nxt_clr_armed  = 1'b0;
      end
      if (fault_now) begin
         // set wins over the clear, and disarms it
         nxt_fault_flag = 1'b1;
         nxt_clr_armed  = 1'b0;
      end
      // master fault disables port and empties tx
      // master select is left as it was
      // slave fault leaves the port enabled
      if (master_fault) begin
         nxt_port_enable = 1'b0;
         nxt_tx_empty    = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         port_enable_ff   <= `SMFD_RST_PORT_ENABLE;
         master_select_ff <= `SMFD_RST_MASTER_SELECT;
         tx_empty_ff      <= `SMFD_RST_TX_EMPTY;
         fault_flag_ff    <= `SMFD_RST_FAULT_FLAG;
         clr_armed_ff     <= 1'b0;
      end else begin
         port_enable_ff   <= nxt_port_enable;
         master_select_ff <= nxt_master_select;
         tx_empty_ff      <= nxt_tx_empty;
         fault_flag_ff    <= nxt_fault_flag;
         clr_armed_ff     <= nxt_clr_armed;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign o_select_fault_flag = fault_flag_ff;
   assign o_port_enable       = port_enable_ff;
   assign o_master_select     = master_select_ff;
   assign o_tx_empty_flag     = tx_empty_ff;
   assign o_xfer_active       = (xfer_ff != smfd_pkg::XFER_IDLE);
   // request in either role when enabled
   assign o_err_irq           = fault_flag_ff & i_error_irq_enable;
   assign o_miso_oe           = slave_on & ~ss_n_s;
   // direction register owns the pins once disabled
   assign o_pins_to_port      = ~port_enable_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence seq_arm;
      fault_flag_ff & i_stat_rd & ~fault_now;
   endsequence

   sequence seq_quiet_write;
      i_ctrl_wr & clr_armed_ff & ~fault_now;
   endsequence

   chk_master_sets_flag: assert property (
      master_fault |=> fault_flag_ff)
      else $error("master select low did not set the fault flag");

   chk_master_irq: assert property (
      master_fault & i_error_irq_enable |=> o_err_irq)
      else $error("master fault gave no error request");

   chk_master_shutdown: assert property (
      master_fault |=> !port_enable_ff && tx_empty_ff && o_pins_to_port
                       && xfer_ff == smfd_pkg::XFER_IDLE)
      else $error("master fault did not shut the port down");

   chk_role_kept: assert property (
      master_fault & ~i_ctrl_wr
      |=> master_select_ff == $past(master_select_ff))
      else $error("fault changed the master select bit");

   chk_slave_deselect: assert property (
      slave_fault |=> fault_flag_ff ##1 fault_flag_ff | $past(i_ctrl_wr))
      else $error("deselect during transfer did not set the flag");

   chk_phase0_start: assert property (
      slave_on & ~i_clock_phase & ss_fall & ~master_select_ff & ~ss_n_s
      & xfer_ff == smfd_pkg::XFER_IDLE |=> xfer_ff == smfd_pkg::XFER_ACTIVE)
      else $error("phase 0 select did not start a transfer");

   chk_phase1_quiet: assert property (
      i_clock_phase & xfer_ff == smfd_pkg::XFER_IDLE & ~master_select_ff
      & ss_rise |=> fault_flag_ff == $past(fault_flag_ff)
      || $past(i_ctrl_wr))
      else $error("phase 1 select without clocks raised a fault");

   chk_slave_stays_on: assert property (
      slave_fault & ~i_ctrl_wr & port_enable_ff |=> port_enable_ff)
      else $error("slave fault disabled the port");

   chk_abort_idle: assert property (
      !port_enable_ff |=> xfer_ff == smfd_pkg::XFER_IDLE)
      else $error("disabled port kept a transfer");

   chk_miso_off: assert property (
      ss_n_s |-> !o_miso_oe ##1 !link_rst_n_ff)
      else $error("deselected slave drove miso or counted clocks");

   chk_clear_seq: assert property (
      seq_arm ##[1:4] seq_quiet_write
      |=> !fault_flag_ff)
      else $error("clear sequence left the flag set");

   chk_fault_beats_clear: assert property (
      i_ctrl_wr & clr_armed_ff & fault_now |=> fault_flag_ff)
      else $error("fault during clear sequence was lost");

endmodule

// ==== tb/smfd_far_master.sv ====
// far-side serial master: drives the select and the link clock
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps

module smfd_far_master (
   input  wire logic i_clock_polarity, // idle level of the link clock
   output logic      o_serial_clock,   // link clock, 6 ns period in frames
   output logic      o_select_n        // select, pulled high when idle
);
   ////////////////////////////////////////////////////////////////////
   // deselected and idle at start, as the pull-up would leave it
   initial begin
      o_select_n     = 1'b1;
      o_serial_clock = 1'b0;
   end

   // clock parked at idle whenever select moves, no free-running
   task automatic drive_select(input logic lvl);
      o_serial_clock = i_clock_polarity;
      o_select_n     = lvl;
   endtask

   // whole periods from idle back to idle; odd offset keeps phase loose
   task automatic pulse_clock(input int n);
      #7;
      repeat (n) begin
         #3 o_serial_clock = ~i_clock_polarity;
         #3 o_serial_clock = i_clock_polarity;
      end
   endtask
endmodule

// ==== tb/test_smfd_top.sv ====
// self-checking bench of the select-fault block
// assumes the far master model drives the pins; strobes at falling edges
`timescale 1ns/1ps

module test_smfd_top;
   logic clk, rst_n, cpol, clock_phase, fde, eie, wr, wen, wms, rd, txl;
   logic sclk, ss_n, flag, pen, ms, txe, irq, moe, p2p, xact;
   int   mismatches = 0;
   int   num_checks = 0;

   ////////////////////////////////////////////////////////////////////
   // bus clock, 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   smfd_far_master i_far (
      .i_clock_polarity (cpol),
      .o_serial_clock   (sclk),
      .o_select_n       (ss_n)
   );

   smfd_top i_dut (
      .i_clk                 (clk),
      .i_rst_n               (rst_n),
      .i_serial_clock_pin    (sclk),
      .i_slave_select_n      (ss_n),
      .i_clock_polarity      (cpol),
      .i_clock_phase         (clock_phase),
      .i_fault_detect_enable (fde),
      .i_error_irq_enable    (eie),
      .i_ctrl_wr             (wr),
      .i_ctrl_port_enable    (wen),
      .i_ctrl_master_select  (wms),
      .i_stat_rd             (rd),
      .i_tx_load             (txl),
      .o_select_fault_flag   (flag),
      .o_port_enable         (pen),
      .o_master_select       (ms),
      .o_tx_empty_flag       (txe),
      .o_err_irq             (irq),
      .o_miso_oe             (moe),
      .o_pins_to_port        (p2p),
      .o_xfer_active         (xact)
   );

   ////////////////////////////////////////////////////////////////////
   // shared helpers; a strobe lasts exactly one bus cycle
   task automatic check(input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic ctrl_write(input logic en, input logic m);
      wr  = 1'b1;
      wen = en;
      wms = m;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask

   task automatic stat_read();
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(1);
   endtask

   // select pin, then enough bus cycles for the synchroniser
   task automatic sel(input logic lvl);
      i_far.drive_select(lvl);
      cyc(6);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // master: fault only when enabled, then recovery actions
   task automatic test_master_fault();
      ctrl_write(1'b1, 1'b1);
      txl = 1'b1;
      cyc(1);
      txl = 1'b0;
      cyc(1);
      check(txe, 1'b0);
      sel(1'b0);
      check(flag, 1'b0);
      fde = 1'b1;
      cyc(6);
      check(flag, 1'b1);
      check(irq, 1'b1);
      check(pen, 1'b0);
      check(txe, 1'b1);
      check(p2p, 1'b1);
      check(ms, 1'b1);
      check(moe, 1'b0);
      $display("master fault test done");
   endtask

   // clear sequence: needs read then write, no fault meanwhile
   task automatic test_clear();
      stat_read();
      ctrl_write(1'b0, 1'b1);
      check(flag, 1'b1);
      sel(1'b1);
      ctrl_write(1'b0, 1'b1);
      check(flag, 1'b1);
      // armed, then a fault lands exactly on the clearing write
      stat_read();
      i_far.drive_select(1'b0);
      cyc(2);
      ctrl_write(1'b0, 1'b1);
      check(flag, 1'b1);
      sel(1'b1);
      stat_read();
      ctrl_write(1'b0, 1'b0);
      check(flag, 1'b0);
      check(irq, 1'b0);
      $display("clear test done");
   endtask

   // slave, phase 0: select alone starts a transfer
   task automatic test_slave_ph0();
      ctrl_write(1'b1, 1'b0);
      sel(1'b0);
      check(moe, 1'b1);
      check(xact, 1'b1);
      sel(1'b1);
      check(flag, 1'b1);
      check(irq, 1'b1);
      eie = 1'b0;
      cyc(1);
      check(irq, 1'b0);
      eie = 1'b1;
      check(pen, 1'b1);
      check(moe, 1'b0);
      check(xact, 1'b0);
      stat_read();
      ctrl_write(1'b1, 1'b0);
      check(flag, 1'b0);
      // a whole byte ends the transfer, so deselect is clean
      sel(1'b0);
      i_far.pulse_clock(8);
      cyc(8);
      check(xact, 1'b0);
      sel(1'b1);
      check(flag, 1'b0);
      $display("slave phase 0 test done");
   endtask

   // slave, phase 1: clock activity starts the transfer
   task automatic test_slave_ph1();
      clock_phase = 1'b1;
      cyc(2);
      sel(1'b0);
      check(xact, 1'b0);
      sel(1'b1);
      check(flag, 1'b0);
      sel(1'b0);
      i_far.pulse_clock(3);
      cyc(8);
      check(xact, 1'b1);
      sel(1'b1);
      check(flag, 1'b1);
      check(pen, 1'b1);
      stat_read();
      ctrl_write(1'b1, 1'b0);
      check(flag, 1'b0);
      clock_phase = 1'b0;
      cyc(2);
      $display("slave phase 1 test done");
   endtask

   // slave abort by turning the port off mid-transfer
   task automatic test_abort();
      sel(1'b0);
      i_far.pulse_clock(3);
      cyc(4);
      check(xact, 1'b1);
      ctrl_write(1'b0, 1'b0);
      cyc(2);
      check(xact, 1'b0);
      check(moe, 1'b0);
      sel(1'b1);
      check(flag, 1'b0);
      ctrl_write(1'b1, 1'b0);
      check(pen, 1'b1);
      $display("abort test done");
   endtask

   ////////////////////////////////////////////////////////////////////
   // hang guard, well beyond the roughly 160 bus cycles the tests need
   initial begin
      #500000;
      mismatches++;
      finish_test();
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      cpol  = 1'b0;
      clock_phase  = 1'b0;
      fde   = 1'b0;
      eie   = 1'b1;
      wr    = 1'b0;
      wen   = 1'b0;
      wms   = 1'b0;
      rd    = 1'b0;
      txl   = 1'b0;
      cyc(8);
      rst_n = 1'b1;
      cyc(1);
      check(flag, 1'b0);
      check(pen, 1'b0);
      check(ms, 1'b0);
      check(txe, 1'b1);
      check(p2p, 1'b1);
      check(xact, 1'b0);
      test_master_fault();
      test_clear();
      test_slave_ph0();
      test_slave_ph1();
      test_abort();
      finish_test();
   end
endmodule
